// File: bench/ussu_core_properties.sv
// Port-level checks for the serial shift unit
`timescale 1ns/10ps
module ussu_core_properties (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire ussu_pkg::ussu_ctrl_t serial_unit_control_i,
    input wire logic                 data_wr_i,
    input wire logic [7:0]           data_wdata_i,
    input wire logic [7:0]           serial_shift_data_o,
    input wire logic                 stat_wr_i,
    input wire ussu_pkg::ussu_stat_t stat_wdata_i,
    input wire ussu_pkg::ussu_stat_t serial_unit_status_o,
    input wire logic                 software_clock_strobe_i,
    input wire logic                 clock_pin_toggle_strobe_i,
    input wire logic                 overflow_irq_o,
    input wire logic                 idle_wake_o,
    input wire logic [2:0]           port_e_direction_i,
    input wire logic                 data_out_o,
    input wire logic                 data_out_oe_o,
    input wire logic                 serial_clock_pin_o
);
    import ussu_pkg::*;
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic       ext     = serial_unit_control_i.external_clock_select;
    wire logic       thr     = serial_unit_control_i.wire_mode == USSU_WM_THREE;
    wire logic       int_clk = thr && !ext && !serial_unit_control_i.clock_edge_select;
    wire logic [3:0] cnt     = serial_unit_status_o.cnt;
    wire logic       ovf     = serial_unit_status_o.counter_overflow_flag;
    sequence s_tick;
        int_clk && !stat_wr_i && (clock_pin_toggle_strobe_i || software_clock_strobe_i);
    endsequence
    sequence s_msb_still;
        (thr && !ext && $stable(serial_shift_data_o))[*2];
    endsequence
    property p_count_step; s_tick ##0 cnt != CNT_MAX |=> cnt == $past(cnt) + 4'h1; endproperty
    property p_wrap; s_tick ##0 cnt == CNT_MAX |=> cnt == CNT_RST && ovf; endproperty
    property p_clear;
        stat_wr_i && stat_wdata_i.counter_overflow_flag && stat_wdata_i.cnt == CNT_RST && !ext
            && !clock_pin_toggle_strobe_i && !software_clock_strobe_i |=> !ovf && cnt == CNT_RST;
    endproperty
    property p_hold; ovf && !stat_wr_i |=> ovf; endproperty
    property p_write_wins; data_wr_i |=> serial_shift_data_o == $past(data_wdata_i); endproperty
    property p_irq; overflow_irq_o == ovf && idle_wake_o == ovf; endproperty
    property p_msb; s_msb_still |-> data_out_o == serial_shift_data_o[MSB_POS]; endproperty
    property p_oe_gate; (thr && !port_e_direction_i[0])[*2] |-> !data_out_oe_o; endproperty
    property p_toggle; clock_pin_toggle_strobe_i && thr |=> serial_clock_pin_o != $past(serial_clock_pin_o); endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step by one");
    a_wrap: assert property (p_wrap) else $error("counter wrap or flag wrong");
    a_clear: assert property (p_clear) else $error("status write did not clear");
    a_hold: assert property (p_hold) else $error("overflow flag dropped alone");
    a_write_wins: assert property (p_write_wins) else $error("written data lost");
    a_irq: assert property (p_irq) else $error("interrupt differs from flag");
    a_msb: assert property (p_msb) else $error("data out not msb");
    a_oe_gate: assert property (p_oe_gate) else $error("data out driven without direction");
    a_toggle: assert property (p_toggle) else $error("clock pin did not toggle");
endmodule : ussu_core_properties

bind ussu_core ussu_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
    .serial_unit_control_i(serial_unit_control_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
    .serial_shift_data_o(serial_shift_data_o), .stat_wr_i(stat_wr_i), .stat_wdata_i(stat_wdata_i),
    .serial_unit_status_o(serial_unit_status_o), .software_clock_strobe_i(software_clock_strobe_i),
    .clock_pin_toggle_strobe_i(clock_pin_toggle_strobe_i), .overflow_irq_o(overflow_irq_o),
    .idle_wake_o(idle_wake_o), .port_e_direction_i(port_e_direction_i), .data_out_o(data_out_o),
    .data_out_oe_o(data_out_oe_o), .serial_clock_pin_o(serial_clock_pin_o));

// File: bench/ussu_core_tb_top.sv
// Self-checking bench for the serial shift unit
`timescale 1ns/10ps
module ussu_core_tb_top;
    import ussu_pkg::*;
    logic       clk, rst, dwr, swr, sws, tgl, tmr, rdy, do_o, do_oe, ck_o, ck_oe, rxv, drop, p_sck, miso, sif;
    logic [7:0] wdat, sdat, rxd, n_drop;
    logic [2:0] dir;
    ussu_ctrl_t ctrl;
    ussu_stat_t swd, st;
    int         n_mismatch, tests_run;
    wire logic  sck_line = ck_oe ? ck_o : p_sck;
    ussu_core dut (.clk_i(clk), .rst_i(rst), .serial_unit_control_i(ctrl), .data_wr_i(dwr),
        .data_wdata_i(wdat), .serial_shift_data_o(sdat), .stat_wr_i(swr), .stat_wdata_i(swd),
        .serial_unit_status_o(st), .software_clock_strobe_i(sws), .clock_pin_toggle_strobe_i(tgl),
        .timer_match_i(tmr), .overflow_irq_o(), .start_irq_o(sif), .idle_wake_o(), .rx_valid_o(rxv),
        .rx_ready_i(rdy), .rx_data_o(rxd), .rx_drop_o(drop), .port_e_direction_i(dir),
        .port_clock_level_i(1'b0), .serial_in_pin_i(miso), .data_out_o(do_o), .data_out_oe_o(do_oe),
        .serial_clock_pin_o(ck_o), .serial_clock_pin_oe_o(ck_oe), .serial_clock_pin_i(sck_line));
    ussu_spi_peer peer (.sck_i(sck_line), .mosi_i(do_o), .mosi_oe_i(do_oe), .sck_o(p_sck), .miso_o(miso));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (drop === 1'b1) n_drop <= n_drop + 8'h01;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // One byte exchange; external clock from the peer, or clock-toggle strobes with a software strobe on every second one
    task automatic xfer(input logic [7:0] mine, input logic [7:0] theirs, input logic ext);
        ctrl = '{USSU_WM_THREE, ext, 1'b0};
        dir = ext ? 3'b001 : 3'b101;
        peer.load(theirs);
        dwr = 1'b1;
        wdat = mine;
        swr = 1'b1;
        swd = '{1'b1, 1'b0, CNT_RST};
        cyc(1);
        dwr = 1'b0;
        swr = 1'b0;
        cyc(8);
        if (ext)
            peer.run_master();
        else
            for (int i = 0; i < 16; i++)
            begin
                tgl = 1'b1;
                sws = i[0];
                cyc(1);
                tgl = 1'b0;
                sws = 1'b0;
                cyc(3);
            end
        cyc(10);
        check({3'h0, st.counter_overflow_flag, st.cnt}, 8'h10);
        check(sdat, theirs);
        check(peer.rx_sh, mine);
    endtask : xfer
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rst, dwr, swr, sws, tgl, tmr, rdy, wdat, swd, n_drop, n_mismatch, tests_run} = '0;
        rst = 1'b1;
        rdy = 1'b1;
        ctrl = '{USSU_WM_THREE, 1'b0, 1'b0};
        dir = 3'b101;
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        xfer(8'hA5, 8'h3C, 1'b1);
        xfer(8'h96, 8'hE1, 1'b0);
        swr = 1'b1;
        swd = '{1'b0, 1'b0, CNT_MAX};
        cyc(1);
        swr = 1'b0;
        check({4'h0, st.cnt}, 8'h0F);
        tgl = 1'b1;
        cyc(1);
        check({3'h0, st.counter_overflow_flag, st.cnt}, 8'h10);
        cyc(1);
        tgl = 1'b0;
        dwr = 1'b1;
        wdat = 8'hC3;
        sws = 1'b1;
        cyc(1);
        dwr = 1'b0;
        sws = 1'b0;
        cyc(1);
        check(sdat, 8'hC3);
        ctrl = '{USSU_WM_THREE, 1'b0, 1'b1};
        dwr = 1'b1;
        wdat = 8'hA5;
        cyc(1);
        dwr = 1'b0;
        repeat (4)
        begin
            tmr = 1'b1;
            cyc(1);
            tmr = 1'b0;
            cyc(3);
        end
        check(sdat, {4'h5, {4{miso}}});
        dir = 3'b000;
        cyc(2);
        check({7'h0, do_oe}, 8'h00);
        dir = 3'b001;
        cyc(2);
        check({7'h0, do_oe}, 8'h01);
        // Two-wire start: data falls while the clock pin stands high
        peer.load(8'hFF);
        ctrl = '{USSU_WM_TWO, 1'b0, 1'b0};
        dir = 3'b100;
        tgl = 1'b1;
        cyc(1);
        tgl = 1'b0;
        cyc(4);
        peer.load(8'h00);
        cyc(4);
        check({7'h0, sif}, 8'h01);
        check({7'h0, ck_o}, 8'h00);
        swr = 1'b1;
        swd = '{1'b0, 1'b1, CNT_RST};
        cyc(1);
        swr = 1'b0;
        cyc(1);
        check({6'h0, sif, ck_o}, 8'h01);
        // Return the clock pin low before the next transfers
        tgl = 1'b1;
        cyc(1);
        tgl = 1'b0;
        // Stall the reader so the fifth byte meets a full queue
        rdy = 1'b0;
        for (int i = 0; i < 5; i++) xfer(8'h5A, 8'h30 + 8'(i), 1'b0);
        check(n_drop, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            check({7'h0, rxv}, 8'h01);
            check(rxd, 8'h30 + 8'(i));
            rdy = 1'b1;
            cyc(1);
            rdy = 1'b0;
            cyc(1);
        end
        check({7'h0, rxv}, 8'h00);
        results();
    end
    initial
    begin
        #100us;
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end
endmodule : ussu_core_tb_top

// File: bench/ussu_spi_peer.sv
// Far-side serial peer: mode 0 shift register, clocks when master
`timescale 1ns/10ps
module ussu_spi_peer (
    input  wire logic sck_i,
    input  wire logic mosi_i,
    input  wire logic mosi_oe_i,
    output logic      sck_o,
    output logic      miso_o
);
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    initial
    begin
        sck_o = 1'b0;
        miso_o = 1'b0;
        tx_sh = 8'h00;
        rx_sh = 8'h00;
    end
    // Caller waits half a period before the first edge
    task automatic load(input logic [7:0] b);
        tx_sh = b;
        miso_o = b[7];
    endtask : load
    // Clock idles low outside frames
    task automatic run_master();
        repeat (8)
        begin
            #80 sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
    endtask : run_master
    // Undriven data line counts as unknown
    always @(posedge sck_i) rx_sh = {rx_sh[6:0], mosi_oe_i ? mosi_i : 1'bx};
    // Refill with inverted bit so a stale line never looks valid
    always @(negedge sck_i)
    begin
        tx_sh = {tx_sh[6:0], ~tx_sh[0]};
        miso_o = tx_sh[7];
    end
endmodule : ussu_spi_peer

// File: src/ussu_core.sv
// Universal serial shift unit: shift register, edge counter, output latch
`timescale 1ns/10ps
import ussu_pkg::*;

// Operation
// - Eight-bit shift register read and written directly by software, unbuffered.
// - Shift register MSB drives data-out or data pin per wire mode.
// - Transparent latch makes output change on edge opposite to sampling.
// - Serial input always taken from the serial-in pin.
// - Four-bit counter readable, writable, with overflow flag raising interrupt.
// - Shift register and counter advance together on software strobe with edge select zero; timer compare match shifts without counting.
// - External clock: counter increments on both clock edges.
// - Shift clock from clock pin, timer compare match, or software strobe.
// - Two-wire start condition raises start flag and interrupt.
// - Two-wire hold clock low after start, or after counter overflow in USSU_WM_TWOH mode only.
// - Three-wire mode acts as SPI mode 0/1, no slave select.
// - Looped master and slave exchange contents after eight clocks.
// - Master clock made by port toggling or clock-toggle strobe.
// - Edge select zero: sample on rising, shift on falling edge.
// - Edge select one: sample on falling, shift on rising edge.
// - Both ends load data and enable driver half period before sampling.
// - Counter cleared to zero before each byte transfer.
// - External clocking overflows after eight pulses, sixteen edges.
// - Overflow interrupt can wake the processor from idle.
// - Software strobe in three-wire: toggle bit inverts clock pin, counts.
// - Write with overflow bit one and count zero clears flag and counter.
// - Output pin driven only when its direction bit is output; the two-wire hold drives the clock pin regardless.
// - Software write coinciding with a shift clock wins; shift skipped.
// - Latch transparent first half cycle externally, always with internal clock.
module ussu_core #(
    parameter int unsigned DATA_WIDTH = DATA_W,
    parameter int unsigned FIFO_D     = FIFO_DEPTH
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Software side
    input  wire ussu_pkg::ussu_ctrl_t  serial_unit_control_i,
    input  wire logic                  data_wr_i,
    input  wire logic [7:0]            data_wdata_i,
    output logic      [7:0]            serial_shift_data_o,
    input  wire logic                  stat_wr_i,
    input  wire ussu_pkg::ussu_stat_t  stat_wdata_i,
    output ussu_pkg::ussu_stat_t       serial_unit_status_o,
    input  wire logic                  software_clock_strobe_i,
    input  wire logic                  clock_pin_toggle_strobe_i,
    input  wire logic                  timer_match_i,
    output logic                       overflow_irq_o,
    output logic                       start_irq_o,
    output logic                       idle_wake_o,
    // Received byte stream
    output logic                       rx_valid_o,
    input  wire logic                  rx_ready_i,
    output logic      [7:0]            rx_data_o,
    output logic                       rx_drop_o,
    // Port pins
    input  wire logic [2:0]            port_e_direction_i,
    input  wire logic                  port_clock_level_i,
    input  wire logic                  serial_in_pin_i,
    output logic                       data_out_o,
    output logic                       data_out_oe_o,
    output logic                       serial_clock_pin_o,
    output logic                       serial_clock_pin_oe_o,
    input  wire logic                  serial_clock_pin_i
);
    import ussu_pkg::*;

    initial
    begin
        if (DATA_WIDTH != 8)
            $error("DATA_WIDTH must be 8");
        if (FIFO_D < 2)
            $error("FIFO_D must be at least 2");
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Both two-wire codes share the open-drain data line and start logic
    function automatic logic ussu_is_two_wire(input ussu_wm_t mode);
        return (mode == USSU_WM_TWO) || (mode == USSU_WM_TWOH);
    endfunction : ussu_is_two_wire

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sck_sync_ff;
    logic [1:0] din_sync_ff;
    logic       sck_prev_ff;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sck_sync_ff <= 2'h0;
            din_sync_ff <= 2'h0;
            sck_prev_ff <= 1'b0;
        end
        else
        begin
            sck_sync_ff <= {sck_sync_ff[0], serial_clock_pin_i};
            din_sync_ff <= {din_sync_ff[0], serial_in_pin_i};
            sck_prev_ff <= sck_sync_ff[1];
        end
    end

    wire sck_s  = sck_sync_ff[1];
    wire din_s  = din_sync_ff[1];
    wire sck_rise = sck_s && !sck_prev_ff;
    wire sck_fall = !sck_s && sck_prev_ff;

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    wire ext_sel  = serial_unit_control_i.external_clock_select;
    wire edge_sel = serial_unit_control_i.clock_edge_select;
    ussu_wm_t wm;
    assign wm = serial_unit_control_i.wire_mode;
    wire two_wire = ussu_is_two_wire(wm);

    // Mode 0 samples on rise and shifts on fall; mode 1 the opposite
    wire ext_sample = ext_sel && (edge_sel ? sck_fall : sck_rise);
    wire ext_shift  = ext_sel && (edge_sel ? sck_rise : sck_fall);
    // Internal: compare match or software strobe shifts in one step
    wire int_clk    = !ext_sel && (edge_sel ? timer_match_i
                                            : software_clock_strobe_i);
    // Counter: both external edges, else the toggle strobe or the software strobe
    wire cnt_tick   = ext_sel ? (sck_rise || sck_fall)
                              : (software_clock_strobe_i ? 1'b1
                                                         : clock_pin_toggle_strobe_i);

    // ------------------------------------------------------------
    // Shift register, sample holding, counter
    // ------------------------------------------------------------
    logic [7:0] shreg_ff;
    logic       sampled_ff;
    logic [3:0] cnt_ff;
    logic       ovf_ff;
    logic       sif_ff;
    logic       hold_ff;
    logic       latch_ff;
    logic       clk_pin_ff;

    // Sampled bit held until the shift edge keeps output stable meanwhile
    wire shift_now = ext_shift || int_clk;
    wire [7:0] nxt_shreg = data_wr_i ? data_wdata_i
                         : shift_now ? {shreg_ff[6:0], ext_sel ? sampled_ff : din_s}
                         : shreg_ff;

    wire       clr_ovf   = stat_wr_i && stat_wdata_i.counter_overflow_flag;
    wire       wrap      = cnt_tick && (cnt_ff == CNT_MAX);
    wire [3:0] nxt_cnt   = stat_wr_i ? stat_wdata_i.cnt
                         : cnt_tick ? cnt_ff + 4'h1
                         : cnt_ff;
    wire       nxt_ovf   = wrap ? 1'b1 : (clr_ovf ? 1'b0 : ovf_ff);

    // Start: data falls while clock high, only in two-wire mode
    logic din_prev_ff;
    wire  start_det = two_wire && sck_s && din_prev_ff && !din_s;
    wire  clr_sif   = stat_wr_i && stat_wdata_i.start_detect_flag;
    wire  nxt_sif   = start_det ? 1'b1 : (clr_sif ? 1'b0 : sif_ff);

    // Hold released when software clears either the start or the overflow flag
    wire  nxt_hold  = (two_wire && ((start_det) ||
                       (wm == USSU_WM_TWOH && wrap))) ? 1'b1
                    : ((clr_sif || clr_ovf) ? 1'b0 : hold_ff);

    // ------------------------------------------------------------
    // State registers, one short block each
    // ------------------------------------------------------------
    // Shift register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            shreg_ff <= DATA_RST;
        else
            shreg_ff <= nxt_shreg;
    end

    // Sampled input bit, held until the shift edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sampled_ff <= 1'b0;
        else if (ext_sample)
            sampled_ff <= din_s;
    end

    // Edge counter
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_ff <= CNT_RST;
        else
            cnt_ff <= nxt_cnt;
    end

    // Overflow flag
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ovf_ff <= 1'b0;
        else
            ovf_ff <= nxt_ovf;
    end

    // Start flag
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sif_ff <= 1'b0;
        else
            sif_ff <= nxt_sif;
    end

    // Clock hold; leaving two-wire mode drops it at once
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            hold_ff <= 1'b0;
        else
            hold_ff <= nxt_hold && two_wire;
    end

    // Previous data level for the start detector
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            din_prev_ff <= 1'b0;
        else
            din_prev_ff <= din_s;
    end

    // ------------------------------------------------------------
    // Output latch and clock pin
    // ------------------------------------------------------------
    // Transparent in first half of cycle (after shift edge) or always internally
    wire latch_open = !ext_sel || (edge_sel ? !sck_s : sck_s) == 1'b0 || shift_now;

    // Open latch shows a freshly written MSB at once, giving setup time
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            latch_ff <= 1'b0;
        else if (latch_open)
            latch_ff <= nxt_shreg[MSB_POS];
    end

    // Toggle state of the clock pin
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            clk_pin_ff <= 1'b0;
        else if (clock_pin_toggle_strobe_i)
            clk_pin_ff <= !clk_pin_ff;
    end

    // Three-wire uses dedicated output; two-wire uses the data line, open drain
    wire sel_three = !ussu_is_two_wire(wm);
    assign data_out_o    = sel_three ? latch_ff : 1'b0;
    assign data_out_oe_o = sel_three ? port_e_direction_i[0]
                                     : (port_e_direction_i[1] && !latch_ff);
    // Clock pin: port level xor toggle state; two-wire hold forces it low
    assign serial_clock_pin_o    = hold_ff ? 1'b0 : (port_clock_level_i ^ clk_pin_ff);
    assign serial_clock_pin_oe_o = port_e_direction_i[2] || hold_ff;

    // ------------------------------------------------------------
    // Status, interrupts, receive stream
    // ------------------------------------------------------------
    assign serial_shift_data_o  = shreg_ff;
    assign serial_unit_status_o = '{counter_overflow_flag: ovf_ff,
                                    start_detect_flag:     sif_ff,
                                    cnt:                   cnt_ff};
    assign overflow_irq_o       = ovf_ff;
    assign start_irq_o          = sif_ff;
    assign idle_wake_o          = ovf_ff;

    logic ovf_prev_ff;
    logic push_ff;
    logic rx_in_ready;

    // Previous overflow level for the rising-edge push
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ovf_prev_ff <= 1'b0;
        else
            ovf_prev_ff <= ovf_ff;
    end

    // One push per rise of the overflow flag
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            push_ff <= 1'b0;
        else
            push_ff <= ovf_ff && !ovf_prev_ff;
    end

    // Copy of each completed byte; a full FIFO drops and reports it
    assign rx_drop_o = push_ff && !rx_in_ready;

    ussu_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_ff),
        .in_ready_o  (rx_in_ready),
        .in_data_i   (shreg_ff),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );
endmodule : ussu_core

// File: src/ussu_fifo.sv
// Small valid/ready FIFO for received bytes
`timescale 1ns/10ps
module ussu_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;

    wire full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    wire empty = (wr_ff == rd_ff);
    wire push  = in_valid_i && !full;
    wire pop   = out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_ff[rd_ff[AW-1:0]];

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= wr_ff + 1'b1;
            if (pop)
                rd_ff <= rd_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
endmodule : ussu_fifo

// File: src/ussu_pkg.sv
// Package for the universal serial shift unit: widths, modes, carriers
package ussu_pkg;

    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CNT_W         = 4;
    localparam logic [7:0]  DATA_RST      = 8'h00;
    localparam logic [3:0]  CNT_RST       = 4'h0;
    localparam logic [3:0]  CNT_MAX       = 4'hF;
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam int unsigned MSB_POS       = 7;

    // Wire mode select
    typedef enum logic [1:0] {
        USSU_WM_OFF   = 2'b00,
        USSU_WM_THREE = 2'b01,
        USSU_WM_TWO   = 2'b10,
        USSU_WM_TWOH  = 2'b11
    } ussu_wm_t;

    // Wire mode and clock source select: wire_mode, external_clock_select, clock_edge_select
    typedef struct packed {
        ussu_wm_t wire_mode;
        logic     external_clock_select;
        logic     clock_edge_select;
    } ussu_ctrl_t;

    typedef struct packed {
        logic       counter_overflow_flag;
        logic       start_detect_flag;
        logic [3:0] cnt;
    } ussu_stat_t;

endpackage : ussu_pkg
